// ==== pi_decode_defs.svh ====
`ifndef PI_DECODE_DEFS_SVH
`define PI_DECODE_DEFS_SVH
`define DESC_W 20
`define BIT_SIMD16 16
`define BIT_RATE 15
`define BIT_LINEAR 14
`define TYPE_HI 13
`define TYPE_LO 12
`define BIT_GROUP 11
`define PHASE_HI 11
`define PHASE_LO 8
`define CTRL_HI 7
`define CTRL_LO 0
`define SIDX_HI 7
`define SIDX_LO 4
`define TYPE_0 2'h0
`define TYPE_1 2'h1
`define TYPE_2 2'h2
`define TYPE_3 2'h3
`define PHASE_ZERO 4'h0
`endif

// ==== pi_decode_pkg.sv ====
package pi_decode_pkg;
	typedef enum logic [7:0] {
		op_none = 8'h01,
		op_imm_offset = 8'h02,
		op_sample_pos = 8'h04,
		op_centroid = 8'h08,
		op_slot_offset = 8'h10,
		op_coarse_map = 8'h20,
		op_coarse_centroid = 8'h40,
		op_coarse_slot_offset = 8'h80
	} op_t;
endpackage

// ==== sample_index_check.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pi_decode_defs.svh"
// ---------------------------------
// Sample index range check
// ---------------------------------
module sample_index_check
(
	input wire logic [3:0] sample_index,
	input wire logic [4:0] forced_sample_count,
	output logic illegal
);
	// Count of 0 or 1 means no multisample limit applies
	always_comb
	begin
		illegal = (forced_sample_count > 5'h01) && ({1'b0, sample_index} >= forced_sample_count);
	end
endmodule // sample_index_check
`default_nettype wire

// ==== pixel_interp_msg_decode.sv ====
// What this block does
// R1 - Sender asks linear only when clip stage enabled non-perspective barycentrics.
// R2 - Interpolation mode bit ignored for coarse to pixel mapping messages.
// R3 - Shading rate bit picks pixel-rate or coarse-rate type decode.
// R4 - Pixel rate types: immediate offset, sample position, centroid, per-slot offset.
// R5 - Coarse rate types: mapping, reserved, coarse centroid, per-slot coarse offset.
// R6 - Sender never requests sample index beyond forced sample count.
// R7 - Non-coarse: bit 11 selects slots 15:0 or 31:16 bypass data.
// R8 - Sender uses low group for 8/16 pixel dispatch, per message for 32.
// R9 - SIMD8 messages always use bypassed data for slots 7:0.
// R10 - Non-coarse shaders ignore bits 10:8.
// R11 - Coarse dispatch: bits 11:8 are a four-bit pixel shader phase.
// R12 - Sender gives nonzero phase only for coarse-rate shaders.
// R13 - Bits 7:0 are controls whose meaning follows the decoded type.
// R14 - Reserved coarse type or illegal sample index flags a descriptor error.
`timescale 1ns/10ps
`default_nettype none
`include "pi_decode_defs.svh"
module pixel_interp_msg_decode
	import pi_decode_pkg::*;
#(
	parameter int DESC_WIDTH = `DESC_W
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic desc_valid,
	input wire logic [DESC_WIDTH-1:0] descriptor,
	input wire logic coarse_dispatch,
	input wire logic nonpersp_enable,
	input wire logic [4:0] forced_sample_count,
	output logic out_valid,
	output op_t op,
	output logic linear_mode,
	output logic high_slot_group,
	output logic simd16,
	output logic [3:0] phase,
	output logic [7:0] msg_ctrl,
	output logic desc_error
);
	// ---------------------------------
	// Reset release
	// ---------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ---------------------------------
	// Decode
	// ---------------------------------
	typedef struct packed {
		logic valid;
		op_t op;
		logic linear;
		logic grp;
		logic simd16;
		logic [3:0] phase;
		logic [7:0] ctrl;
		logic err;
	} state_t;

	state_t st;
	state_t next_st;
	logic [1:0] mtype;
	logic coarse_rate;
	logic sidx_bad;

	function automatic op_t decode_type(input logic coarse, input logic [1:0] t);
		op_t r;
		r = op_none;
		if (!coarse)
		begin
			case (t) // R4
				`TYPE_0: r = op_imm_offset;
				`TYPE_1: r = op_sample_pos;
				`TYPE_2: r = op_centroid;
				`TYPE_3: r = op_slot_offset;
				default: r = op_none;
			endcase
		end
		else
		begin
			case (t) // R5
				`TYPE_0: r = op_coarse_map;
				`TYPE_2: r = op_coarse_centroid;
				`TYPE_3: r = op_coarse_slot_offset;
				default: r = op_none;
			endcase
		end
		return r;
	endfunction

	assign mtype = descriptor[`TYPE_HI:`TYPE_LO];
	assign coarse_rate = descriptor[`BIT_RATE]; // R3

	sample_index_check u_sidx
	(
		.sample_index(descriptor[`SIDX_HI:`SIDX_LO]),
		.forced_sample_count(forced_sample_count),
		.illegal(sidx_bad)
	);

	always_comb
	begin
		next_st = st;
		next_st.valid = desc_valid;
		if (desc_valid)
		begin
			next_st.op = decode_type(coarse_rate, mtype); // R3
			next_st.simd16 = descriptor[`BIT_SIMD16];
			// Mapping message takes no interpolation mode
			next_st.linear = (next_st.op == op_coarse_map) ? 1'b0 : descriptor[`BIT_LINEAR]; // R2
			// Linear only usable when clip stage enabled it
			if (!nonpersp_enable)
				next_st.linear = 1'b0; // R1
			if (coarse_dispatch)
			begin
				next_st.phase = descriptor[`PHASE_HI:`PHASE_LO]; // R11
				next_st.grp = 1'b0;
			end
			else
			begin
				// Bits 10:8 dropped; SIMD8 pinned to low group
				next_st.phase = `PHASE_ZERO; // R10
				next_st.grp = descriptor[`BIT_GROUP] & descriptor[`BIT_SIMD16]; // R7 R9
			end
			next_st.ctrl = descriptor[`CTRL_HI:`CTRL_LO]; // R13
			next_st.err = (coarse_rate && mtype == `TYPE_1) ||
				(!coarse_rate && mtype == `TYPE_1 && sidx_bad); // R14
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '{valid: 1'b0, op: op_none, linear: 1'b0, grp: 1'b0, simd16: 1'b0,
				phase: `PHASE_ZERO, ctrl: 8'h00, err: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign out_valid = st.valid;
	assign op = st.op;
	assign linear_mode = st.linear;
	assign high_slot_group = st.grp;
	assign simd16 = st.simd16;
	assign phase = st.phase;
	assign msg_ctrl = st.ctrl;
	assign desc_error = st.err;

	// ---------------------------------
	// Checks
	// ---------------------------------
	a_map_linear_off: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
		(desc_valid && descriptor[`BIT_RATE] && mtype == `TYPE_0) |=> !linear_mode)
		else $error("linear mode set on mapping message");
	a_pixel_type_dec: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
		(desc_valid && !descriptor[`BIT_RATE] && mtype == `TYPE_2) |=> op == op_centroid)
		else $error("pixel centroid not decoded");
	a_coarse_type_dec: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
		(desc_valid && descriptor[`BIT_RATE] && mtype == `TYPE_3) |=> op == op_coarse_slot_offset)
		else $error("coarse slot offset not decoded");
	a_rate_select: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
		(desc_valid && descriptor[`BIT_RATE] && mtype == `TYPE_0) |=> op == op_coarse_map)
		else $error("coarse rate not applied");
	a_slot_group: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
		(desc_valid && !coarse_dispatch && descriptor[`BIT_SIMD16])
		|=> high_slot_group == $past(descriptor[`BIT_GROUP]))
		else $error("slot group wrong");
	a_simd8_low: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
		(desc_valid && !descriptor[`BIT_SIMD16]) |=> !high_slot_group)
		else $error("simd8 used high group");
	a_phase_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
		(desc_valid && !coarse_dispatch) |=> phase == `PHASE_ZERO)
		else $error("phase not zero outside coarse");
	a_phase_take: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
		(desc_valid && coarse_dispatch) |=> phase == $past(descriptor[`PHASE_HI:`PHASE_LO]))
		else $error("phase not captured");
	a_ctrl_pass: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
		desc_valid |=> msg_ctrl == $past(descriptor[`CTRL_HI:`CTRL_LO]))
		else $error("control bits lost");
	a_reserved_err: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
		(desc_valid && descriptor[`BIT_RATE] && mtype == `TYPE_1) |=> desc_error && out_valid)
		else $error("reserved type not flagged");

	// Multi-step checks: a take, then its answer one edge later
	sequence taken_s;
		desc_valid;
	endsequence
	sequence answered_s;
		out_valid;
	endsequence
	// Index limit worked out here, so a broken range check cannot hide
	sequence bad_index_s;
		desc_valid && !descriptor[`BIT_RATE] && mtype == `TYPE_1 && forced_sample_count > 5'h01
			&& {1'b0, descriptor[`SIDX_HI:`SIDX_LO]} >= forced_sample_count;
	endsequence
	sequence flagged_s;
		out_valid && desc_error;
	endsequence
	a_answer_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
		taken_s |=> answered_s)
		else $error("no answer after take");
	a_answer_drop: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
		!desc_valid |=> !out_valid)
		else $error("answer without take");
	a_index_err: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
		bad_index_s |=> flagged_s)
		else $error("illegal sample index not flagged");
	a_clean_no_err: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
		(desc_valid && mtype != `TYPE_1) |=> !desc_error)
		else $error("error on legal type");
	a_linear_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
		(desc_valid && !nonpersp_enable) |=> !linear_mode)
		else $error("linear mode without enable");
endmodule // pixel_interp_msg_decode
`default_nettype wire

// ==== msg_sender.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------
// Shader sender
// ----------------
module msg_sender
(
	input wire logic core_clk,
	input wire logic go,
	input wire logic bad,
	input wire logic [31:0] r,
	output logic desc_valid,
	output logic [19:0] descriptor,
	output logic coarse_dispatch,
	output logic nonpersp_enable,
	output logic [4:0] forced_sample_count
);
	logic [19:0] d;
	initial
	begin
		desc_valid = 1'b0;
		descriptor = 20'h0;
		coarse_dispatch = 1'b0;
		nonpersp_enable = 1'b0;
		forced_sample_count = 5'h0;
	end
	// Faulty fields only when bad is set, so errors are always commanded
	always @(posedge core_clk)
	begin
		d = r[31:12];
		d[19] = 1'b0;
		if (!r[1])
			d[14] = 1'b0;
		if (!r[0] && !d[16])
			d[11] = 1'b0;
		if (!r[0] && !bad)
			d[10:8] = 3'h0;
		if (!bad && d[15] && d[13:12] == 2'h1)
			d[13:12] = 2'h2;
		if (!bad && !d[15] && d[13:12] == 2'h1 && r[6:2] > 5'h1 && {1'b0, d[7:4]} >= r[6:2])
			d[7:4] = 4'(d[7:4] % r[6:2]);
		desc_valid <= go;
		descriptor <= d;
		coarse_dispatch <= r[0];
		nonpersp_enable <= r[1];
		forced_sample_count <= r[6:2];
	end
endmodule // msg_sender
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pi_decode_pkg::*;
	logic core_clk, resetn, go, bad, run, pend, desc_valid, coarse_dispatch, nonpersp_enable;
	logic [31:0] r, x;
	logic [19:0] descriptor;
	logic [4:0] forced_sample_count;
	logic out_valid, linear_mode, high_slot_group, simd16, desc_error;
	logic e_lin, e_grp, e_s16, e_err;
	logic [3:0] phase, e_ph;
	logic [7:0] msg_ctrl, e_ctl, e_op, eo;
	op_t op;
	int error_cnt, checks, ty, ix, fc;
	msg_sender msg_sender_i (.core_clk(core_clk), .go(go), .bad(bad), .r(r),
		.desc_valid(desc_valid), .descriptor(descriptor), .coarse_dispatch(coarse_dispatch),
		.nonpersp_enable(nonpersp_enable), .forced_sample_count(forced_sample_count));
	pixel_interp_msg_decode pixel_interp_msg_decode_i (.core_clk(core_clk), .resetn(resetn),
		.desc_valid(desc_valid), .descriptor(descriptor), .coarse_dispatch(coarse_dispatch),
		.nonpersp_enable(nonpersp_enable), .forced_sample_count(forced_sample_count),
		.out_valid(out_valid), .op(op), .linear_mode(linear_mode),
		.high_slot_group(high_slot_group), .simd16(simd16), .phase(phase),
		.msg_ctrl(msg_ctrl), .desc_error(desc_error));
	always #20 core_clk = ~core_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task stop_test;
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------
	// Reference model
	// ----------------
	always @(posedge core_clk)
	begin
		ty = descriptor[13:12];
		ix = descriptor[7:4];
		fc = forced_sample_count;
		if (descriptor[15])
			eo = (ty == 0) ? 8'h20 : (ty == 1) ? 8'h01 : (ty == 2) ? 8'h40 : 8'h80;
		else
			eo = 8'h02 << ty;
		pend <= desc_valid;
		e_op <= eo;
		e_lin <= descriptor[14] && nonpersp_enable && eo != 8'h20;
		e_grp <= !coarse_dispatch && descriptor[11] && descriptor[16];
		e_ph <= coarse_dispatch ? descriptor[11:8] : 4'h0;
		e_err <= ty == 1 && (descriptor[15] || (fc > 1 && ix >= fc));
		e_ctl <= descriptor[7:0];
		e_s16 <= descriptor[16];
	end
	always @(negedge core_clk)
		if (run)
		begin
			cmp("out_valid", {7'h0, pend}, {7'h0, out_valid});
			if (pend)
			begin
				cmp("op", e_op, op);
				cmp("linear_mode", {7'h0, e_lin}, {7'h0, linear_mode});
				cmp("slot_group", {7'h0, e_grp}, {7'h0, high_slot_group});
				cmp("phase", {4'h0, e_ph}, {4'h0, phase});
				cmp("msg_ctrl", e_ctl, msg_ctrl);
				cmp("flags", {6'h0, e_s16, e_err}, {6'h0, simd16, desc_error});
			end
		end
	initial
	begin
		core_clk = 1'b0;
		resetn = 1'b0;
		go = 1'b0;
		bad = 1'b0;
		r = 32'h0;
		x = 32'h0cee;
		run = 1'b0;
		pend = 1'b0;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(posedge core_clk);
		#1;
		cmp("reset_op", 8'h01, op);
		cmp("reset_out", 8'h00, {out_valid, linear_mode, high_slot_group, simd16, phase});
		cmp("reset_ctl", 8'h00, msg_ctrl | {7'h0, desc_error});
		@(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		run = 1'b1;
		// Mostly back-to-back traffic; second half also breaks sender rules
		for (int i = 0; i < 600; i++)
		begin
			@(posedge core_clk);
			x = xs(x);
			r <= x;
			go <= x[3] | x[4];
			bad <= i > 300;
		end
		@(posedge core_clk);
		go <= 1'b0;
		repeat (4) @(posedge core_clk);
		stop_test();
	end
endmodule // testbench
`default_nettype wire
